// ==== design/fpc_clock_map.vh ====
// Register map, field positions, reset values and state codes of the clock mode controller
`ifndef FPC_CLOCK_MAP_VH
`define FPC_CLOCK_MAP_VH

// Register word offsets on the plain register port
`define FPC_ADDR_W          3
`define FPC_ADDR_SRC_CTRL   3'h0
`define FPC_ADDR_PLL_CTRL   3'h1
`define FPC_ADDR_STATUS     3'h2
`define FPC_ADDR_MODE       3'h3
`define FPC_ADDR_MULT       3'h4

// Source control register fields
`define FPC_CLOCK_SOURCE_SELECT_HI         7
`define FPC_CLOCK_SOURCE_SELECT_LO         6
`define FPC_REF_DIVIDER_HI         5
`define FPC_REF_DIVIDER_LO         3
`define FPC_INTERNAL_REF_SELECT_BIT       2
`define FPC_EXT_REF_CLOCK_ENABLE_BIT     1
`define FPC_LP_BIT          0
`define FPC_SRC_CTRL_RST    8'h04

// PLL, lock and monitor control register fields
`define FPC_LOSS_LOCK_IRQ_ENABLE_BIT       7
`define FPC_PLL_SELECT_BIT        6
`define FPC_CME_BIT         5
`define FPC_VCO_MULTIPLIER_SELECT_HI         3
`define FPC_VCO_MULTIPLIER_SELECT_LO         0
`define FPC_PLL_CTRL_RST    8'h01
`define FPC_PLL_CTRL_WMASK  8'hEF

// Status register fields
`define FPC_LOCK_LOST_STICKY_BIT        7
`define FPC_LOCK_BIT        6
`define FPC_PLLST_BIT       5
`define FPC_IREFST_BIT      4
`define FPC_CLKST_HI        3
`define FPC_CLKST_LO        2

// Clock source select codes
`define FPC_SRC_FLL         2'h0
`define FPC_SRC_INT         2'h1
`define FPC_SRC_EXT         2'h2
`define FPC_SRC_PLL         2'h3

// Debug link clock source codes
`define FPC_LINK_OFF        2'h0
`define FPC_LINK_FLL        2'h1
`define FPC_LINK_DCO_HALF   2'h2

// Multiplier field codes and factors
`define FPC_VCO_MULTIPLIER_SELECT_RESERVED   4'h0
`define FPC_VCO_MULTIPLIER_SELECT_MAX        4'hA
`define FPC_MULT_STEP       6'h04
`define FPC_MULT_CAP        6'h28
`define FPC_MULT_NONE       6'h00
`define FPC_REF_DIVIDER_NONE       3'h0

// Internal synchronisation depth of the control word
`define FPC_SYNC_STAGES     2
`define FPC_CTRL_W          16

// One-hot operating states
`define FPC_ST_FEI          9'h001
`define FPC_ST_FEE          9'h002
`define FPC_ST_FBI          9'h004
`define FPC_ST_FBE          9'h008
`define FPC_ST_PEE          9'h010
`define FPC_ST_PBE          9'h020
`define FPC_ST_BLPI         9'h040
`define FPC_ST_BLPE         9'h080
`define FPC_ST_STOP         9'h100

`endif

// ==== design/fpc_sync_pipe.v ====
// Delay pipeline that carries written control bits into the mode logic
`timescale 1ns/1ps
`default_nettype none
`include "fpc_clock_map.vh"

module fpc_sync_pipe
(
  // Clock and reset
  input  wire                     CLK,
  input  wire                     RSTN,
  // Control word in and out
  input  wire [`FPC_CTRL_W-1:0]   D_IN,
  input  wire [`FPC_CTRL_W-1:0]   RST_VAL,
  output wire [`FPC_CTRL_W-1:0]   D_OUT
);

  wire [`FPC_CTRL_W-1:0] stage_w [0:`FPC_SYNC_STAGES];

  assign stage_w[0] = D_IN;

  // One register per stage; stages reset to zero, the constant tied at the instance drives the output instead
  genvar gi;
  generate
    for (gi = 0; gi < `FPC_SYNC_STAGES; gi = gi + 1)
    begin : g_stage
      reg [`FPC_CTRL_W-1:0] q_r;
      always @(posedge CLK or negedge RSTN)
      begin
        if (!RSTN)
          q_r <= {`FPC_CTRL_W{1'b0}};
        else
          q_r <= stage_w[gi];
      end
      assign stage_w[gi+1] = q_r;
    end
  endgenerate

  // Outputs follow reset constant until the pipe has filled once
  reg [`FPC_SYNC_STAGES-1:0] fill_r;
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      fill_r <= {`FPC_SYNC_STAGES{1'b0}};
    else
      fill_r <= {fill_r[`FPC_SYNC_STAGES-2:0], 1'b1};
  end

  assign D_OUT = fill_r[`FPC_SYNC_STAGES-1] ? stage_w[`FPC_SYNC_STAGES] : RST_VAL;

endmodule // fpc_sync_pipe

`default_nettype wire

// ==== design/fpc_clock_ctrl.v ====
// Clock generator mode controller: registers, mode state machine, lock and monitor logic
`timescale 1ns/1ps
`default_nettype none
`include "fpc_clock_map.vh"

module fpc_clock_ctrl
(
  // Clock and reset
  input  wire        CLK,
  input  wire        RSTN,
  // Register port
  input  wire [2:0]  ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [7:0]  RDATA,
  // Analog side status
  input  wire        BACKGROUND_DEBUG_MODE,
  input  wire        STOP_REQ,
  input  wire        FLL_LOCKED,
  input  wire        PLL_LOCKED,
  input  wire        EXT_CLK_LOST,
  // Clock controls
  output reg  [1:0]  GEN_OUTPUT_SRC,
  output reg  [1:0]  DEBUG_LINK_SRC,
  output reg         FLL_ENABLE,
  output reg         PLL_ENABLE,
  output reg         REF_INTERNAL,
  output reg  [2:0]  REF_DIVIDER,
  output reg  [5:0]  PLL_MULT,
  output reg         EXT_REF_CLOCK_ENABLE,
  // Requests
  output reg         LOSS_LOCK_IRQ,
  output reg         EXT_CLK_RESET_REQ
);

  // Software-visible control bits
  reg  [1:0] clock_source_select_r;
  reg  [2:0] ref_divider_r;
  reg        internal_ref_select_r;
  reg        ext_ref_clock_enable_r;
  reg        low_power_bypass_r;
  reg        loss_lock_irq_enable_r;
  reg        pll_select_r;
  reg        ext_clock_monitor_enable_r;
  reg  [3:0] vco_multiplier_select_r;

  // State and lock tracking
  reg  [8:0] mode_r;
  reg  [8:0] mode_nxt;
  reg        lock_lost_sticky_r;
  reg        lock_seen_r;
  reg        lock_r;

  wire [`FPC_CTRL_W-1:0] ctrl_w;
  wire [`FPC_CTRL_W-1:0] ctrl_sync_w;
  wire [`FPC_CTRL_W-1:0] ctrl_rst_w;

  // Factor applied by the PLL for a multiplier code
  function [5:0] vco_factor;
    input [3:0] code;
    begin
      if (code == `FPC_VCO_MULTIPLIER_SELECT_RESERVED)
        vco_factor = `FPC_MULT_NONE;
      else if (code > `FPC_VCO_MULTIPLIER_SELECT_MAX)
        vco_factor = `FPC_MULT_CAP;
      else
        vco_factor = {2'b00, code} * `FPC_MULT_STEP;
    end
  endfunction

  // Requested state from the synchronised selection bits
  function [8:0] target_mode;
    input [1:0] clock_source_select;
    input       internal_ref_select;
    input       pll_select;
    input       lp;
    input [2:0] ref_divider;
    input       background_debug_mode;
    input [8:0] cur;
    begin
      target_mode = cur;  // Unsupported combination: previous clock stays
      case (clock_source_select)
        `FPC_SRC_FLL:
        begin
          if (internal_ref_select && !pll_select && ref_divider == `FPC_REF_DIVIDER_NONE)
            target_mode = `FPC_ST_FEI;
          else if (!internal_ref_select && !pll_select)
            target_mode = `FPC_ST_FEE;
          else if (!internal_ref_select && pll_select)
            target_mode = `FPC_ST_PEE;
        end
        `FPC_SRC_INT:
        begin
          if (internal_ref_select && lp && !background_debug_mode)
            target_mode = `FPC_ST_BLPI;
          else if (internal_ref_select && ref_divider == `FPC_REF_DIVIDER_NONE)
            target_mode = `FPC_ST_FBI;
        end
        `FPC_SRC_EXT:
        begin
          if (!internal_ref_select && lp && !background_debug_mode)
            target_mode = `FPC_ST_BLPE;
          else if (!internal_ref_select && pll_select)
            target_mode = `FPC_ST_PBE;
          else if (!internal_ref_select)
            target_mode = `FPC_ST_FBE;
        end
        `FPC_SRC_PLL:
        begin
          if (!internal_ref_select && pll_select)
            target_mode = `FPC_ST_PEE;
        end
        default:
          target_mode = cur;
      endcase
    end
  endfunction

  // Allowed moves between state pairs; stop can be entered and left from any
  function allowed_move;
    input [8:0] a;
    input [8:0] b;
    reg   [8:0] p;
    begin
      p = a | b;
      allowed_move = (a == b) || p[8] ||
        (p == (`FPC_ST_FEI | `FPC_ST_FEE)) || (p == (`FPC_ST_FEI | `FPC_ST_FBI)) ||
        (p == (`FPC_ST_FEI | `FPC_ST_FBE)) || (p == (`FPC_ST_FEE | `FPC_ST_FBI)) ||
        (p == (`FPC_ST_FEE | `FPC_ST_FBE)) || (p == (`FPC_ST_FBI | `FPC_ST_FBE)) ||
        (p == (`FPC_ST_FBI | `FPC_ST_BLPI)) || (p == (`FPC_ST_FBE | `FPC_ST_BLPE)) ||
        (p == (`FPC_ST_FBE | `FPC_ST_PBE)) || (p == (`FPC_ST_PBE | `FPC_ST_PEE)) ||
        (p == (`FPC_ST_PBE | `FPC_ST_BLPE));
    end
  endfunction

  // Index of a one-hot state for the mode readback
  function [3:0] mode_index;
    input [8:0] m;
    integer k;
    begin
      mode_index = 4'h0;
      for (k = 0; k < 9; k = k + 1)
        if (m[k])
          mode_index = k[3:0];
    end
  endfunction

  // Register writes land at once
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      clock_source_select_r      <= 2'h0;
      ref_divider_r              <= 3'h0;
      internal_ref_select_r      <= 1'b1;
      ext_ref_clock_enable_r     <= 1'b0;
      low_power_bypass_r         <= 1'b0;
      loss_lock_irq_enable_r     <= 1'b0;
      pll_select_r               <= 1'b0;
      ext_clock_monitor_enable_r <= 1'b0;
      vco_multiplier_select_r    <= 4'h1;
    end
    else if (WR && ADDR == `FPC_ADDR_SRC_CTRL)
    begin
      clock_source_select_r  <= WDATA[`FPC_CLOCK_SOURCE_SELECT_HI:`FPC_CLOCK_SOURCE_SELECT_LO];
      ref_divider_r          <= WDATA[`FPC_REF_DIVIDER_HI:`FPC_REF_DIVIDER_LO];
      internal_ref_select_r  <= WDATA[`FPC_INTERNAL_REF_SELECT_BIT];
      ext_ref_clock_enable_r <= WDATA[`FPC_EXT_REF_CLOCK_ENABLE_BIT];
      low_power_bypass_r     <= WDATA[`FPC_LP_BIT];
    end
    else if (WR && ADDR == `FPC_ADDR_PLL_CTRL)
    begin
      loss_lock_irq_enable_r     <= WDATA[`FPC_LOSS_LOCK_IRQ_ENABLE_BIT];
      pll_select_r               <= WDATA[`FPC_PLL_SELECT_BIT];
      ext_clock_monitor_enable_r <= WDATA[`FPC_CME_BIT];
      vco_multiplier_select_r    <= WDATA[`FPC_VCO_MULTIPLIER_SELECT_HI:`FPC_VCO_MULTIPLIER_SELECT_LO];
    end
  end

  // Selection word carried across the internal synchronisation delay
  assign ctrl_w = {clock_source_select_r, ref_divider_r, internal_ref_select_r,
                   low_power_bypass_r, pll_select_r, vco_multiplier_select_r,
                   BACKGROUND_DEBUG_MODE, STOP_REQ, 2'b00};
  assign ctrl_rst_w = {2'h0, 3'h0, 1'b1, 1'b0, 1'b0, 4'h1, 1'b0, 1'b0, 2'b00};

  fpc_sync_pipe u_sync
  (
    .CLK     (CLK),
    .RSTN    (RSTN),
    .D_IN    (ctrl_w),
    .RST_VAL (ctrl_rst_w),
    .D_OUT   (ctrl_sync_w)
  );

  wire [1:0] s_clock_source_select  = ctrl_sync_w[15:14];
  wire [2:0] s_ref_divider  = ctrl_sync_w[13:11];
  wire       s_internal_ref_select = ctrl_sync_w[10];
  wire       s_lp    = ctrl_sync_w[9];
  wire       s_pll_select  = ctrl_sync_w[8];
  wire [3:0] s_vco_multiplier_select  = ctrl_sync_w[7:4];
  wire       s_bdm   = ctrl_sync_w[3];
  wire       s_stop  = ctrl_sync_w[2];

  // Next state: stop overrides, otherwise move only along an allowed pair
  always @*
  begin
    mode_nxt = target_mode(s_clock_source_select, s_internal_ref_select, s_pll_select, s_lp, s_ref_divider, s_bdm, mode_r);
    if (s_stop)
      mode_nxt = `FPC_ST_STOP;
    else if (mode_r == `FPC_ST_STOP)
      mode_nxt = target_mode(s_clock_source_select, s_internal_ref_select, s_pll_select, s_lp, s_ref_divider, s_bdm, `FPC_ST_FEI);
    else if (!allowed_move(mode_r, mode_nxt))
      mode_nxt = mode_r;
  end

  // State register; illegal codes fall back to the default mode
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      mode_r <= `FPC_ST_FEI;
    else
    begin
      case (mode_r)
        `FPC_ST_FEI, `FPC_ST_FEE, `FPC_ST_FBI, `FPC_ST_FBE, `FPC_ST_PEE,
        `FPC_ST_PBE, `FPC_ST_BLPI, `FPC_ST_BLPE, `FPC_ST_STOP:
          mode_r <= mode_nxt;
        default:
          mode_r <= `FPC_ST_FEI;
      endcase
    end
  end

  // Per-state outputs; loop enables follow the PLL select bit
  wire fll_mode_w = |(mode_r & (`FPC_ST_FEI | `FPC_ST_FEE | `FPC_ST_FBI | `FPC_ST_FBE));
  wire pll_mode_w = |(mode_r & (`FPC_ST_PEE | `FPC_ST_PBE));

  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      GEN_OUTPUT_SRC <= `FPC_SRC_FLL;
      DEBUG_LINK_SRC <= `FPC_LINK_FLL;
      FLL_ENABLE     <= 1'b1;
      PLL_ENABLE     <= 1'b0;
      REF_INTERNAL   <= 1'b1;
      REF_DIVIDER    <= 3'h0;
      PLL_MULT       <= `FPC_MULT_STEP;
    end
    else
    begin
      FLL_ENABLE   <= fll_mode_w && !s_pll_select;
      PLL_ENABLE   <= pll_mode_w && s_pll_select;
      REF_INTERNAL <= s_internal_ref_select;
      REF_DIVIDER  <= s_ref_divider;
      PLL_MULT     <= vco_factor(s_vco_multiplier_select);
      if (fll_mode_w)
        DEBUG_LINK_SRC <= `FPC_LINK_FLL;
      else if (pll_mode_w && s_bdm)
        DEBUG_LINK_SRC <= `FPC_LINK_DCO_HALF;
      else
        DEBUG_LINK_SRC <= `FPC_LINK_OFF;
      case (mode_r)
        `FPC_ST_FEI, `FPC_ST_FEE:
          GEN_OUTPUT_SRC <= `FPC_SRC_FLL;
        `FPC_ST_FBI, `FPC_ST_BLPI:
          GEN_OUTPUT_SRC <= `FPC_SRC_INT;
        `FPC_ST_FBE, `FPC_ST_PBE, `FPC_ST_BLPE:
          GEN_OUTPUT_SRC <= `FPC_SRC_EXT;
        `FPC_ST_PEE:
          GEN_OUTPUT_SRC <= `FPC_SRC_PLL;
        default:
          GEN_OUTPUT_SRC <= GEN_OUTPUT_SRC;                  // Stop holds the last choice
      endcase
    end
  end

  // Lock tracking; a control change restarts acquisition so stale lock is not trusted
  wire loop_locked_w = (FLL_ENABLE && FLL_LOCKED) || (PLL_ENABLE && PLL_LOCKED);
  wire ctrl_change_w = (ctrl_sync_w[15:4] != ctrl_w[15:4]) || (mode_nxt != mode_r);
  wire lol_event_w   = lock_seen_r && !loop_locked_w && !ctrl_change_w;
  wire lock_lost_sticky_clear_w  = WR && ADDR == `FPC_ADDR_STATUS && WDATA[`FPC_LOCK_LOST_STICKY_BIT];

  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      lock_seen_r        <= 1'b0;
      lock_r             <= 1'b0;
      lock_lost_sticky_r <= 1'b0;
    end
    else
    begin
      lock_r      <= loop_locked_w && !ctrl_change_w;
      lock_seen_r <= loop_locked_w && !ctrl_change_w;
      if (lol_event_w)
        lock_lost_sticky_r <= 1'b1;                          // set wins over clear
      else if (lock_lost_sticky_clear_w)
        lock_lost_sticky_r <= 1'b0;
    end
  end

  // Request outputs
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      LOSS_LOCK_IRQ        <= 1'b0;
      EXT_CLK_RESET_REQ    <= 1'b0;
      EXT_REF_CLOCK_ENABLE <= 1'b0;
    end
    else
    begin
      LOSS_LOCK_IRQ        <= loss_lock_irq_enable_r && lock_lost_sticky_r;
      EXT_CLK_RESET_REQ    <= ext_clock_monitor_enable_r && EXT_CLK_LOST;
      EXT_REF_CLOCK_ENABLE <= ext_ref_clock_enable_r;
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      RDATA <= 8'h00;
    else if (RD)
    begin
      case (ADDR)
        `FPC_ADDR_SRC_CTRL:
          RDATA <= {clock_source_select_r, ref_divider_r, internal_ref_select_r,
                    ext_ref_clock_enable_r, low_power_bypass_r};
        `FPC_ADDR_PLL_CTRL:
          RDATA <= {loss_lock_irq_enable_r, pll_select_r, ext_clock_monitor_enable_r,
                    1'b0, vco_multiplier_select_r};
        `FPC_ADDR_STATUS:
          RDATA <= {lock_lost_sticky_r, lock_r, PLL_ENABLE, REF_INTERNAL, GEN_OUTPUT_SRC, 2'b00};
        `FPC_ADDR_MODE:
          RDATA <= {2'b00, DEBUG_LINK_SRC, mode_index(mode_r)};
        `FPC_ADDR_MULT:
          RDATA <= {2'b00, PLL_MULT};
        default:
          RDATA <= 8'h00;
      endcase
    end
    else
      RDATA <= 8'h00;
  end

endmodule // fpc_clock_ctrl

`default_nettype wire

// ==== bench/fpc_clock_ctrl_asserts.sv ====
// Port-level assertions for the clock mode controller
`timescale 1ns/1ps
`default_nettype none
`include "fpc_clock_map.vh"

module fpc_clock_ctrl_asserts
(
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RSTN,
  // Register port
  input wire logic [2:0] ADDR,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // Status and clock controls
  input wire logic       EXT_CLK_LOST,
  input wire logic [1:0] GEN_OUTPUT_SRC,
  input wire logic [1:0] DEBUG_LINK_SRC,
  input wire logic       FLL_ENABLE,
  input wire logic       PLL_ENABLE,
  input wire logic [5:0] PLL_MULT,
  input wire logic       LOSS_LOCK_IRQ,
  input wire logic       EXT_CLK_RESET_REQ
);
  // One clock domain, reset masks every check
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  // Read cycles that must answer in the next cycle
  sequence s_unmapped_rd;
    RD && (ADDR > `FPC_ADDR_MULT);
  endsequence
  sequence s_mult_rd;
    RD && (ADDR == `FPC_ADDR_MULT);
  endsequence

  loop_excl_a: assert property (!(FLL_ENABLE && PLL_ENABLE))
    else $error("both loops enabled");
  mult_set_a: assert property (PLL_MULT <= `FPC_MULT_CAP && PLL_MULT[1:0] == 2'b00)
    else $error("multiplier factor outside set");
  rdata_quiet_a: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data without read");
  unmapped_rd_a: assert property (s_unmapped_rd |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  mult_rd_a: assert property (s_mult_rd |=> RDATA == {2'b00, $past(PLL_MULT)})
    else $error("multiplier readback wrong");
  ext_rst_a: assert property (EXT_CLK_RESET_REQ |-> $past(EXT_CLK_LOST))
    else $error("reset request without lost clock");
  lock_clear_a: assert property ($fell(LOSS_LOCK_IRQ) |-> ($past(WR) || $past(WR, 2)))
    else $error("lock interrupt dropped without write");
  link_pll_a: assert property ((PLL_ENABLE && GEN_OUTPUT_SRC == `FPC_SRC_PLL) |-> DEBUG_LINK_SRC != `FPC_LINK_FLL)
    else $error("debug clock from stopped loop");
endmodule // fpc_clock_ctrl_asserts

bind fpc_clock_ctrl fpc_clock_ctrl_asserts i_fpc_clock_ctrl_asserts
(
  .CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .EXT_CLK_LOST(EXT_CLK_LOST),
  .GEN_OUTPUT_SRC(GEN_OUTPUT_SRC), .DEBUG_LINK_SRC(DEBUG_LINK_SRC), .FLL_ENABLE(FLL_ENABLE),
  .PLL_ENABLE(PLL_ENABLE), .PLL_MULT(PLL_MULT), .LOSS_LOCK_IRQ(LOSS_LOCK_IRQ),
  .EXT_CLK_RESET_REQ(EXT_CLK_RESET_REQ)
);
`default_nettype wire

// ==== bench/fpc_clock_ctrl_bench.sv ====
// Self-checking bench for the clock mode controller
`timescale 1ns/1ps
`default_nettype none
`include "fpc_clock_map.vh"

module fpc_clock_ctrl_bench;
  // Design inputs
  logic       clk, rstn, wr, rd, background_debug_mode, stop_req, fll_locked, pll_locked, ext_lost;
  logic [2:0] addr;
  logic [7:0] wdata;
  // Design outputs
  wire  [7:0] rdata;
  wire  [1:0] gen_src, link_src;
  wire        fll_en, pll_en, ref_int, ext_ref_en, irq, ext_rst_req;
  wire  [2:0] ref_div;
  wire  [5:0] pll_mult;
  // Run bookkeeping
  int         fail_count, check_count;
  logic [7:0] rv;

  fpc_clock_ctrl i_fpc_clock_ctrl
  (
    .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .BACKGROUND_DEBUG_MODE(background_debug_mode), .STOP_REQ(stop_req), .FLL_LOCKED(fll_locked), .PLL_LOCKED(pll_locked),
    .EXT_CLK_LOST(ext_lost), .GEN_OUTPUT_SRC(gen_src), .DEBUG_LINK_SRC(link_src), .FLL_ENABLE(fll_en),
    .PLL_ENABLE(pll_en), .REF_INTERNAL(ref_int), .REF_DIVIDER(ref_div), .PLL_MULT(pll_mult),
    .EXT_REF_CLOCK_ENABLE(ext_ref_en), .LOSS_LOCK_IRQ(irq), .EXT_CLK_RESET_REQ(ext_rst_req)
  );

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Verdict and end of run
  task give_verdict;
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Case compare so unknowns never match
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Let edges pass, then step off the edge
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Write cycle; trailing step keeps strobe edits in separate time steps
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask

  // Read cycle; data stands only in the following cycle
  task rd_reg(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Poll state index with a bounded count
  task wait_mode(input logic [3:0] m);
    int n;
    for (n = 0; n < 20; n++)
    begin
      rd_reg(`FPC_ADDR_MODE, rv);
      if (rv[3:0] === m)
        break;
    end
    if (n == 20)
    begin
      fail_count++;
      $display("Error at %0t: mode %h expected %h", $time, rv[3:0], m);
      give_verdict;
    end
  endtask

  // Reach a mode and compare the clock controls with it
  task chk_mode(input logic [3:0] m, input logic [1:0] s, input logic f, input logic p, input logic [1:0] k);
    wait_mode(m);
    cyc(2);
    chk(gen_src, s);
    chk(fll_en, f);
    chk(pll_en, p);
    chk(link_src, k);
    rd_reg(`FPC_ADDR_STATUS, rv);
    chk(rv[3:2], s);
  endtask

  // Reset values and default mode
  task t_reset;
    rd_reg(`FPC_ADDR_SRC_CTRL, rv);
    chk(rv, `FPC_SRC_CTRL_RST);
    rd_reg(`FPC_ADDR_PLL_CTRL, rv);
    chk(rv, `FPC_PLL_CTRL_RST);
    chk_mode(4'h0, `FPC_SRC_FLL, 1'b1, 1'b0, `FPC_LINK_FLL);
    chk(ref_int, 1'b1);
    chk(ref_div, 3'h0);
    rd_reg(3'h6, rv);
    chk(rv, 8'h00);
  endtask

  // Every multiplier code, bit 4 written high but never stored
  task t_mult;
    int c;
    int e;
    for (c = 0; c < 16; c++)
    begin
      e = (c == 0) ? 0 : (c > 10) ? 40 : 4 * c;
      wr_reg(`FPC_ADDR_PLL_CTRL, 8'h10 | c[7:0]);
      cyc(5);
      chk(pll_mult, e[7:0]);
      rd_reg(`FPC_ADDR_MULT, rv);
      chk(rv, e[7:0]);
      rd_reg(`FPC_ADDR_PLL_CTRL, rv);
      chk(rv, c[7:0]);
    end
    wr_reg(`FPC_ADDR_PLL_CTRL, 8'h05);
  endtask

  // Walk the modes, one refused step included
  task t_modes;
    wr_reg(`FPC_ADDR_SRC_CTRL, 8'h44);
    rd_reg(`FPC_ADDR_SRC_CTRL, rv);
    chk(rv, 8'h44);
    chk(gen_src, `FPC_SRC_FLL);
    chk_mode(4'h2, `FPC_SRC_INT, 1'b1, 1'b0, `FPC_LINK_FLL);
    wr_reg(`FPC_ADDR_SRC_CTRL, 8'h98);
    chk_mode(4'h3, `FPC_SRC_EXT, 1'b1, 1'b0, `FPC_LINK_FLL);
    chk(ref_int, 1'b0);
    chk(ref_div, 3'h3);
    wr_reg(`FPC_ADDR_SRC_CTRL, 8'h18);
    chk_mode(4'h1, `FPC_SRC_FLL, 1'b1, 1'b0, `FPC_LINK_FLL);
    wr_reg(`FPC_ADDR_SRC_CTRL, 8'h98);
    chk_mode(4'h3, `FPC_SRC_EXT, 1'b1, 1'b0, `FPC_LINK_FLL);
    wr_reg(`FPC_ADDR_PLL_CTRL, 8'h45);
    chk_mode(4'h5, `FPC_SRC_EXT, 1'b0, 1'b1, `FPC_LINK_OFF);
    wr_reg(`FPC_ADDR_SRC_CTRL, 8'h18);
    chk_mode(4'h4, `FPC_SRC_PLL, 1'b0, 1'b1, `FPC_LINK_OFF);
    chk(pll_mult, 8'd20);
    background_debug_mode <= 1'b1;
    cyc(6);
    chk(link_src, `FPC_LINK_DCO_HALF);
    background_debug_mode <= 1'b0;
    // PLL still selected: no mode decodes, state stays
    wr_reg(`FPC_ADDR_SRC_CTRL, 8'h04);
    cyc(8);
    rd_reg(`FPC_ADDR_MODE, rv);
    chk(rv[3:0], 4'h4);
    // Default mode is not a neighbour of PLL engaged: move refused
    wr_reg(`FPC_ADDR_PLL_CTRL, 8'h05);
    cyc(8);
    rd_reg(`FPC_ADDR_MODE, rv);
    chk(rv[3:0], 4'h4);
    chk(pll_en, 1'b0);
    wr_reg(`FPC_ADDR_PLL_CTRL, 8'h45);
    wr_reg(`FPC_ADDR_SRC_CTRL, 8'h98);
    wait_mode(4'h5);
    wr_reg(`FPC_ADDR_PLL_CTRL, 8'h05);
    wait_mode(4'h3);
    wr_reg(`FPC_ADDR_SRC_CTRL, 8'h04);
    chk_mode(4'h0, `FPC_SRC_FLL, 1'b1, 1'b0, `FPC_LINK_FLL);
  endtask

  // Clock monitor, stop entry and read-only mode register
  task t_monitor;
    ext_lost <= 1'b1;
    cyc(4);
    chk(ext_rst_req, 1'b0);
    wr_reg(`FPC_ADDR_SRC_CTRL, 8'h06);
    wr_reg(`FPC_ADDR_PLL_CTRL, 8'h21);
    cyc(3);
    chk(ext_ref_en, 1'b1);
    chk(ext_rst_req, 1'b1);
    ext_lost <= 1'b0;
    cyc(3);
    chk(ext_rst_req, 1'b0);
    wr_reg(`FPC_ADDR_PLL_CTRL, 8'h01);
    stop_req <= 1'b1;
    wait_mode(4'h8);
    stop_req <= 1'b0;
    wait_mode(4'h0);
    wr_reg(`FPC_ADDR_MODE, 8'h03);
    rd_reg(`FPC_ADDR_MODE, rv);
    chk(rv[3:0], 4'h0);
  endtask

  // Lost lock: sticky flag, masked and unmasked request, clear by one
  task t_lock;
    fll_locked <= 1'b1;
    cyc(6);
    fll_locked <= 1'b0;
    cyc(6);
    chk(irq, 1'b0);
    rd_reg(`FPC_ADDR_STATUS, rv);
    chk(rv[7], 1'b1);
    wr_reg(`FPC_ADDR_PLL_CTRL, 8'h81);
    cyc(2);
    chk(irq, 1'b1);
    fll_locked <= 1'b1;
    wr_reg(`FPC_ADDR_STATUS, 8'h00);
    cyc(2);
    chk(irq, 1'b1);
    wr_reg(`FPC_ADDR_STATUS, 8'h80);
    cyc(2);
    chk(irq, 1'b0);
  endtask

  // Main sequence
  initial
  begin
    fail_count = 0;
    check_count = 0;
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    background_debug_mode = 1'b0;
    stop_req = 1'b0;
    fll_locked = 1'b0;
    pll_locked = 1'b0;
    ext_lost = 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    cyc(1);
    t_reset;
    t_mult;
    t_modes;
    t_monitor;
    t_lock;
    give_verdict;
  end
endmodule // fpc_clock_ctrl_bench
`default_nettype wire
